/* File: core/oaf_core.v */
// Purpose: accumulator, flags, direct/extended address and branch sequencing
// Assumes: i_op/i_mode/i_opnd accepted on i_start while o_busy low
// Notes:   one cycle per processor cycle, gated by a bus-rate enable
`timescale 1ns/100ps
`include "oaf_map.vh"
// Contract
// - 8-bit accumulator feeds and takes all results except branch and bit-test ones (pc and carry)
// - carry set on add carry or sub borrow
// - shifts and bit-test branch also drive carry; logic ops leave it
// - 8-bit flags register: mask plus five flags
// - direct mode: high address byte forced zero
// - extended mode: high byte then low byte fetched
// - half-carry records carry from bit 3
// - decimal adjust chooses correction from H and C
// - branch: next instruction if false, target if true
// - timing counted in bus-rate clock cycles
// - index, stack pointer, pc are internal registers
// - operand location follows the instruction's address mode
// - interrupt mask set blocks all interrupts
// - negative flag set on negative result
module oaf_core #(
    parameter DIV = 8'h01
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // instruction request
    input  wire        i_start,
    input  wire [3:0]  i_op,
    input  wire [1:0]  i_mode,
    input  wire [7:0]  i_opnd,
    input  wire [7:0]  i_bcond,
    input  wire        i_set_mask,
    input  wire        i_clr_mask,
    // memory bus
    input  wire [7:0]  i_rdata,
    output reg  [15:0] o_addr,
    output reg         o_rd,
    // interrupt request in and accepted out
    input  wire        i_irq,
    output reg         o_irq_take,
    // state
    output reg  [7:0]  o_acc,
    output reg  [7:0]  o_flags,
    output reg         o_busy,
    output reg         o_done,
    output reg  [15:0] o_pc,
    output reg  [15:0] o_hx,
    output reg  [15:0] o_sp
);
    localparam S_IDLE = 3'h0;
    localparam S_EXTH = 3'h1;
    localparam S_EXTL = 3'h2;
    localparam S_READ = 3'h3;
    localparam S_EXEC = 3'h4;
    reg  [2:0]  st_r;
    reg  [7:0]  div_r;
    reg         tick_r;
    reg  [3:0]  op_r;
    reg  [7:0]  opnd_r;
    reg  [7:0]  bcond_r;
    reg  [7:0]  ahi_r;
    reg  [7:0]  acc_nxt;
    reg  [7:0]  flg_nxt;
    reg  [8:0]  sum;
    reg  [4:0]  lo;
    reg  [7:0]  cor;
    reg         pc_we;
    reg  [15:0] pc_d;
    wire [15:0] pc_q;
    wire [15:0] hx_q;
    wire [15:0] sp_q;
    // ----------------------------------------
    // bus-rate cycle enable
    // ----------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_r  <= `OAF_DIV_RST;
            tick_r <= 1'b0;
        end else if (div_r <= 8'h01) begin
            div_r  <= DIV;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r - 8'h01;
            tick_r <= 1'b0;
        end
    end
    // ----------------------------------------
    // internal register store
    // ----------------------------------------
    oaf_regs u_regs (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_pc_we (pc_we),
        .i_pc_d  (pc_d),
        .i_hx_we (1'b0),
        .i_hx_d  (16'h0000),
        .i_sp_we (1'b0),
        .i_sp_d  (16'h0000),
        .o_pc    (pc_q),
        .o_hx    (hx_q),
        .o_sp    (sp_q)
    );
    // ----------------------------------------
    // alu and flags
    // ----------------------------------------
    function [8:0] add9;
        input [7:0] a;
        input [7:0] b;
        input       c;
        begin
            add9 = {1'b0, a} + {1'b0, b} + {8'h00, c};
        end
    endfunction
    always @* begin
        acc_nxt = o_acc;
        flg_nxt = o_flags;
        sum     = 9'h000;
        lo      = 5'h00;
        cor     = 8'h00;
        case (op_r)
            `OAF_OP_ADD, `OAF_OP_ADC: begin
                sum = add9(o_acc, opnd_r, (op_r == `OAF_OP_ADC) & o_flags[`OAF_FLG_C]);
                lo  = {1'b0, o_acc[3:0]} + {1'b0, opnd_r[3:0]}
                    + {4'h0, (op_r == `OAF_OP_ADC) & o_flags[`OAF_FLG_C]};
                acc_nxt = sum[7:0];
                flg_nxt[`OAF_FLG_C] = sum[8];
                flg_nxt[`OAF_FLG_H] = lo[4];
                flg_nxt[`OAF_FLG_V] = (o_acc[7] == opnd_r[7]) & (sum[7] != o_acc[7]);
            end
            `OAF_OP_SUB, `OAF_OP_SBC: begin
                sum = add9(o_acc, ~opnd_r, ~((op_r == `OAF_OP_SBC) & o_flags[`OAF_FLG_C]));
                acc_nxt = sum[7:0];
                flg_nxt[`OAF_FLG_C] = ~sum[8];
                flg_nxt[`OAF_FLG_V] = (o_acc[7] != opnd_r[7]) & (sum[7] != o_acc[7]);
            end
            `OAF_OP_AND: acc_nxt = o_acc & opnd_r;
            `OAF_OP_ORA: acc_nxt = o_acc | opnd_r;
            `OAF_OP_EOR: acc_nxt = o_acc ^ opnd_r;
            `OAF_OP_LDA: acc_nxt = opnd_r;
            `OAF_OP_LSL: begin
                acc_nxt = {o_acc[6:0], 1'b0};
                flg_nxt[`OAF_FLG_C] = o_acc[7];
            end
            `OAF_OP_LSR: begin
                acc_nxt = {1'b0, o_acc[7:1]};
                flg_nxt[`OAF_FLG_C] = o_acc[0];
            end
            `OAF_OP_ROL: begin
                acc_nxt = {o_acc[6:0], o_flags[`OAF_FLG_C]};
                flg_nxt[`OAF_FLG_C] = o_acc[7];
            end
            `OAF_OP_ROR: begin
                acc_nxt = {o_flags[`OAF_FLG_C], o_acc[7:1]};
                flg_nxt[`OAF_FLG_C] = o_acc[0];
            end
            `OAF_OP_DAA: begin
                if (o_flags[`OAF_FLG_H] || (o_acc[3:0] > 4'h9))
                    cor[3:0] = 4'h6;
                if (o_flags[`OAF_FLG_C] || (o_acc > 8'h99)) begin
                    cor[7:4] = 4'h6;
                    flg_nxt[`OAF_FLG_C] = 1'b1;
                end
                acc_nxt = o_acc + cor;
            end
            `OAF_OP_BTB: flg_nxt[`OAF_FLG_C] = |(opnd_r & bcond_r);
            default: acc_nxt = o_acc;
        endcase
        if (op_r != `OAF_OP_BRA && op_r != `OAF_OP_BTB && op_r != `OAF_OP_NOP) begin
            flg_nxt[`OAF_FLG_N] = acc_nxt[7];
            flg_nxt[`OAF_FLG_Z] = (acc_nxt == 8'h00);
        end
    end
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @* begin
        pc_we = 1'b0;
        pc_d  = pc_q;
        if (tick_r && st_r == S_EXEC) begin
            pc_we = 1'b1;
            if ((op_r == `OAF_OP_BRA && bcond_r[0]) ||
                (op_r == `OAF_OP_BTB && flg_nxt[`OAF_FLG_C]))
                pc_d = pc_q + {{8{opnd_r[7]}}, opnd_r};
            else
                pc_d = pc_q + 16'h0001;
        end
    end
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= S_IDLE;
            op_r <= `OAF_OP_NOP;
            opnd_r <= 8'h00;
            bcond_r <= 8'h00;
            ahi_r <= 8'h00;
            o_acc <= 8'h00;
            o_flags <= `OAF_FLG_RST;
            o_addr <= 16'h0000;
            o_rd <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_irq_take <= 1'b0;
            o_pc <= `OAF_PC_RST;
            o_hx <= `OAF_HX_RST;
            o_sp <= `OAF_SP_RST;
        end else begin
            o_done <= 1'b0;
            o_irq_take <= i_irq & ~o_flags[`OAF_FLG_I] & ~o_busy;
            o_pc <= pc_q;
            o_hx <= hx_q;
            o_sp <= sp_q;
            if (i_set_mask)
                o_flags[`OAF_FLG_I] <= 1'b1;
            else if (i_clr_mask)
                o_flags[`OAF_FLG_I] <= 1'b0;
            if (tick_r) begin
                case (st_r)
                    S_IDLE: begin
                        o_rd <= 1'b0;
                        if (i_start) begin
                            op_r <= i_op;
                            opnd_r <= i_opnd;
                            bcond_r <= i_bcond;
                            o_busy <= 1'b1;
                            case (i_mode)
                                `OAF_MD_DIR: begin
                                    o_addr <= {8'h00, i_opnd};
                                    o_rd <= 1'b1;
                                    st_r <= S_READ;
                                end
                                `OAF_MD_EXT: begin
                                    o_addr <= pc_q + 16'h0001;
                                    o_rd <= 1'b1;
                                    st_r <= S_EXTH;
                                end
                                default: st_r <= S_EXEC;
                            endcase
                        end
                    end
                    S_EXTH: begin
                        ahi_r <= i_rdata;
                        o_addr <= pc_q + 16'h0002;
                        st_r <= S_EXTL;
                    end
                    S_EXTL: begin
                        o_addr <= {ahi_r, i_rdata};
                        st_r <= S_READ;
                    end
                    S_READ: begin
                        opnd_r <= i_rdata;
                        o_rd <= 1'b0;
                        st_r <= S_EXEC;
                    end
                    S_EXEC: begin
                        o_acc <= acc_nxt;
                        o_flags[`OAF_FLG_V] <= flg_nxt[`OAF_FLG_V];
                        o_flags[`OAF_FLG_H] <= flg_nxt[`OAF_FLG_H];
                        o_flags[`OAF_FLG_N] <= flg_nxt[`OAF_FLG_N];
                        o_flags[`OAF_FLG_Z] <= flg_nxt[`OAF_FLG_Z];
                        o_flags[`OAF_FLG_C] <= flg_nxt[`OAF_FLG_C];
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        st_r <= S_IDLE;
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule // oaf_core

/* File: core/oaf_map.vh */
// Purpose: constants for the operand address and flags core
// Assumes: 8-bit data, 16-bit address
// Notes:   flag bit positions follow the usual V,1,1,H,I,N,Z,C layout
`ifndef OAF_MAP_VH
`define OAF_MAP_VH
`define OAF_FLG_C      0
`define OAF_FLG_Z      1
`define OAF_FLG_N      2
`define OAF_FLG_I      3
`define OAF_FLG_H      4
`define OAF_FLG_V      7
`define OAF_FLG_RST    8'h68
`define OAF_PC_RST     16'h0000
`define OAF_SP_RST     16'h00FF
`define OAF_HX_RST     16'h0000
`define OAF_DIV_RST    8'h01
// operation codes on i_op
`define OAF_OP_NOP     4'h0
`define OAF_OP_ADD     4'h1
`define OAF_OP_ADC     4'h2
`define OAF_OP_SUB     4'h3
`define OAF_OP_SBC     4'h4
`define OAF_OP_AND     4'h5
`define OAF_OP_ORA     4'h6
`define OAF_OP_EOR     4'h7
`define OAF_OP_LSL     4'h8
`define OAF_OP_LSR     4'h9
`define OAF_OP_ROL     4'hA
`define OAF_OP_ROR     4'hB
`define OAF_OP_DAA     4'hC
`define OAF_OP_LDA     4'hD
`define OAF_OP_BRA     4'hE
`define OAF_OP_BTB     4'hF
// address modes on i_mode
`define OAF_MD_INH     2'h0
`define OAF_MD_IMM     2'h1
`define OAF_MD_DIR     2'h2
`define OAF_MD_EXT     2'h3
`endif

/* File: core/oaf_regs.v */
// Purpose: register store holding hx, sp and pc inside the core
// Assumes: single clock, async active-high reset
// Notes:   read data are registered
`timescale 1ns/100ps
`include "oaf_map.vh"
module oaf_regs (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // write side
    input  wire        i_pc_we,
    input  wire [15:0] i_pc_d,
    input  wire        i_hx_we,
    input  wire [15:0] i_hx_d,
    input  wire        i_sp_we,
    input  wire [15:0] i_sp_d,
    // registered read side
    output reg  [15:0] o_pc,
    output reg  [15:0] o_hx,
    output reg  [15:0] o_sp
);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pc <= `OAF_PC_RST;
            o_hx <= `OAF_HX_RST;
            o_sp <= `OAF_SP_RST;
        end else begin
            if (i_pc_we) o_pc <= i_pc_d;
            if (i_hx_we) o_hx <= i_hx_d;
            if (i_sp_we) o_sp <= i_sp_d;
        end
    end
endmodule // oaf_regs

/* File: test/oaf_core_monitor.sv */
// Purpose: port checker for oaf_core
// Assumes: one clock, i_rst async high
// Notes:   captures each request while idle
`timescale 1ns/100ps
`include "oaf_map.vh"
module oaf_core_monitor #(
    parameter DIV = 8'h01
) (
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_start,
    input wire [3:0]  i_op,
    input wire [1:0]  i_mode,
    input wire [7:0]  i_opnd,
    input wire        i_irq,
    input wire [15:0] o_addr,
    input wire        o_rd,
    input wire        o_irq_take,
    input wire [7:0]  o_acc,
    input wire [7:0]  o_flags,
    input wire        o_busy,
    input wire        o_done
);
    // ----
    // request capture
    // ----
    reg  [3:0] op_r;
    reg  [1:0] md_r;
    reg  [7:0] v_r;
    reg  [7:0] a_r;
    wire [8:0] sum = {1'b0, a_r} + {1'b0, v_r};
    wire [4:0] hs  = {1'b0, a_r[3:0]} + {1'b0, v_r[3:0]};
    wire       add = (op_r == `OAF_OP_ADD) && (md_r == `OAF_MD_IMM);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            {op_r, md_r, v_r, a_r} <= 22'h0;
        else if (i_start && !o_busy)
            {op_r, md_r, v_r, a_r} <= {i_op, i_mode, i_opnd, o_acc};
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_add_res; o_done && add |-> o_acc == sum[7:0]; endproperty
    a_add_res: assert property (p_add_res) else $error("add result wrong");
    property p_add_c; o_done && add |-> o_flags[`OAF_FLG_C] == sum[8]; endproperty
    a_add_c: assert property (p_add_c) else $error("add carry wrong");
    property p_add_h; o_done && add |-> o_flags[`OAF_FLG_H] == hs[4]; endproperty
    a_add_h: assert property (p_add_h) else $error("half carry wrong");
    property p_fixed; o_flags[6:5] == 2'b11; endproperty
    a_fixed: assert property (p_fixed) else $error("flag fill bits wrong");
    property p_dir;
        $rose(o_busy) && md_r == `OAF_MD_DIR |-> o_rd && o_addr == {8'h00, v_r};
    endproperty
    a_dir: assert property (p_dir) else $error("direct address wrong");
    property p_ext;
        $rose(o_busy) && md_r == `OAF_MD_EXT |=> o_addr == $past(o_addr) + 16'h0001;
    endproperty
    a_ext: assert property (p_ext) else $error("extended fetch order wrong");
    property p_time; $rose(o_busy) && md_r == `OAF_MD_DIR |-> ##2 o_done; endproperty
    a_time: assert property (p_time) else $error("direct timing wrong");
    property p_neg;
        o_done && op_r != `OAF_OP_NOP && op_r != `OAF_OP_BRA && op_r != `OAF_OP_BTB
            |-> o_flags[`OAF_FLG_N] == o_acc[7];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    property p_keep; o_done && op_r == `OAF_OP_BRA |-> $stable(o_flags); endproperty
    a_keep: assert property (p_keep) else $error("branch changed flags");
    property p_irq;
        o_irq_take |-> $past(i_irq) && !$past(o_busy) && !$past(o_flags[`OAF_FLG_I]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt taken while masked");
    cover property ($rose(o_busy) && md_r == `OAF_MD_EXT);
    cover property (o_done && op_r == `OAF_OP_DAA);
    cover property (o_irq_take);
endmodule // oaf_core_monitor
bind oaf_core oaf_core_monitor #(.DIV(DIV)) i_mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op), .i_mode(i_mode),
    .i_opnd(i_opnd), .i_irq(i_irq), .o_addr(o_addr), .o_rd(o_rd),
    .o_irq_take(o_irq_take), .o_acc(o_acc), .o_flags(o_flags), .o_busy(o_busy),
    .o_done(o_done));

/* File: test/oaf_mem.sv */
// Purpose: byte memory seen by the core
// Assumes: byte = addr low ^ addr high ^ 5A
// Notes:   released bus shows changing junk
`timescale 1ns/100ps
module oaf_mem (
    input  wire        i_clk,
    input  wire [15:0] i_addr,
    input  wire        i_rd,
    output reg  [7:0]  o_data
);
    reg [7:0] last_r;
    always @* o_data = i_rd ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A) : ~last_r;
    always @(posedge i_clk) last_r <= o_data;
endmodule // oaf_mem

/* File: test/oaf_core_tb_top.sv */
// Purpose: self-checking bench for oaf_core
// Assumes: DIV 1, memory model oaf_mem
// Notes:   inputs change 1 ns after the edge
`timescale 1ns/100ps
`include "oaf_map.vh"
module oaf_core_tb_top;
    reg         i_clk, i_rst, i_start, i_irq, i_set_mask, i_clr_mask;
    reg  [3:0]  i_op;
    reg  [1:0]  i_mode;
    reg  [7:0]  i_opnd, i_bcond;
    wire [7:0]  i_rdata, o_acc, o_flags;
    wire [15:0] o_addr, o_pc, o_hx, o_sp;
    wire        o_rd, o_irq_take, o_busy, o_done;
    integer     failures, num_checks, cycles;
    reg  [15:0] p;
    reg  [7:0]  hi, lo;
    oaf_core #(.DIV(8'h01)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start),
        .i_op(i_op), .i_mode(i_mode), .i_opnd(i_opnd), .i_bcond(i_bcond),
        .i_set_mask(i_set_mask), .i_clr_mask(i_clr_mask), .i_rdata(i_rdata),
        .o_addr(o_addr), .o_rd(o_rd), .i_irq(i_irq), .o_irq_take(o_irq_take),
        .o_acc(o_acc), .o_flags(o_flags), .o_busy(o_busy), .o_done(o_done),
        .o_pc(o_pc), .o_hx(o_hx), .o_sp(o_sp));
    oaf_mem i_mem (.i_clk(i_clk), .i_addr(o_addr), .i_rd(o_rd), .o_data(i_rdata));
    // ----
    // helpers
    // ----
    function [7:0] mf(input [15:0] a);
        mf = a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    task chk(input [15:0] exp, input [15:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t exp %h got %h", $time, exp, got);
            end
        end
    endtask
    task run(input [3:0] op, input [1:0] md, input [7:0] v, input [7:0] bc);
        integer k;
        reg [15:0] ncyc;
        begin
            ncyc = (md == `OAF_MD_DIR) ? 16'h0003 : 16'h0002;
            if (md == `OAF_MD_EXT) ncyc = 16'h0005;
            {i_op, i_mode, i_opnd, i_bcond, i_start} = {op, md, v, bc, 1'b1};
            for (k = 0; k < 12 && o_done !== 1'b1; k = k + 1) begin
                @(posedge i_clk); #1;
                if (o_busy === 1'b1) i_start = 1'b0;
            end
            chk(16'h0001, {15'h0, o_done});
            chk(ncyc, k[15:0]);
            repeat (2) @(posedge i_clk);
            #1;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // ----
    // tests
    // ----
    task t_arith;
        begin
            run(`OAF_OP_LDA, `OAF_MD_IMM, 8'h3A, 8'h00);
            run(`OAF_OP_ADD, `OAF_MD_IMM, 8'hC8, 8'h00);
            chk(16'h0002, {8'h0, o_acc});
            chk(16'h0011, {11'h0, o_flags[4], 3'h0, o_flags[0]});
            run(`OAF_OP_SUB, `OAF_MD_IMM, 8'h03, 8'h00);
            chk(16'h01FF, {o_flags[`OAF_FLG_C], o_acc});
            chk(16'h0001, {15'h0, o_flags[`OAF_FLG_N]});
            run(`OAF_OP_LDA, `OAF_MD_IMM, 8'h81, 8'h00);
            run(`OAF_OP_LSL, `OAF_MD_INH, 8'h00, 8'h00);
            chk(16'h0102, {o_flags[`OAF_FLG_C], o_acc});
            run(`OAF_OP_BTB, `OAF_MD_IMM, 8'h10, 8'h01);
            chk(16'h0000, {15'h0, o_flags[`OAF_FLG_C]});
            $display("test arith done");
        end
    endtask
    task t_daa(input [7:0] a, input [7:0] b, input [8:0] exp);
        begin
            run(`OAF_OP_LDA, `OAF_MD_IMM, a, 8'h00);
            run(`OAF_OP_ADD, `OAF_MD_IMM, b, 8'h00);
            run(`OAF_OP_DAA, `OAF_MD_INH, 8'h00, 8'h00);
            chk({7'h0, exp}, {7'h0, o_flags[`OAF_FLG_C], o_acc});
            $display("test daa done");
        end
    endtask
    task t_mem;
        begin
            run(`OAF_OP_LDA, `OAF_MD_DIR, 8'h40, 8'h00);
            chk({8'h0, mf(16'h0040)}, {8'h0, o_acc});
            p = o_pc;
            hi = mf(p + 16'h0001);
            lo = mf(p + 16'h0002);
            run(`OAF_OP_LDA, `OAF_MD_EXT, 8'h00, 8'h00);
            chk({8'h0, mf({hi, lo})}, {8'h0, o_acc});
            $display("test memory done");
        end
    endtask
    task t_branch;
        begin
            p = o_pc;
            run(`OAF_OP_BRA, `OAF_MD_INH, 8'hF0, 8'h01);
            chk(p - 16'h0010, o_pc);
            p = o_pc;
            lo = o_flags;
            run(`OAF_OP_BRA, `OAF_MD_INH, 8'h10, 8'h00);
            chk(p + 16'h0001, o_pc);
            chk({8'h0, lo}, {8'h0, o_flags});
            $display("test branch done");
        end
    endtask
    task t_irq;
        begin
            {i_set_mask, i_irq} = 2'b11;
            repeat (3) @(posedge i_clk);
            #1;
            i_set_mask = 1'b0;
            chk(16'h0008, {12'h0, o_flags[3], o_irq_take, 2'h0});
            i_clr_mask = 1'b1;
            repeat (3) @(posedge i_clk);
            #1;
            chk(16'h0001, {15'h0, o_irq_take});
            {i_set_mask, i_clr_mask} = 2'b11;
            repeat (3) @(posedge i_clk);
            #1;
            chk(16'h0002, {14'h0, o_flags[`OAF_FLG_I], o_irq_take});
            {i_set_mask, i_clr_mask, i_irq} = 3'b000;
            $display("test mask done");
        end
    endtask
    // ----
    // clock, timeout, main
    // ----
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            give_verdict;
        end
    end
    initial begin
        {failures, num_checks, cycles} = 96'h0;
        {i_rst, i_start, i_irq, i_set_mask, i_clr_mask} = 5'b10000;
        {i_op, i_mode, i_opnd, i_bcond} = 22'h0;
        repeat (6) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk(16'h0068, {8'h0, o_flags});
        chk(16'h00FF, o_sp);
        chk(16'h0000, o_hx);
        @(posedge i_clk);
        #1;
        t_arith;
        t_daa(8'h15, 8'h27, 9'h042);
        t_daa(8'h09, 8'h08, 9'h017);
        t_daa(8'h99, 8'h99, 9'h198);
        t_mem;
        t_branch;
        t_irq;
        give_verdict;
    end
endmodule // oaf_core_tb_top
